// *** pkg/pmc_pkg.sv ***
// Package: constants and carrier types for the CPU power mode controller
`default_nettype none
package pmc_pkg;
   // ****************************************
   // Register map
   // ****************************************
   localparam logic [7:0] PMC_ADDR_POWER_CONTROL = 8'h87;
   localparam logic [7:0] PMC_RESET_POWER_CONTROL = 8'h00;
   localparam int         PMC_BIT_IDLE = 0;
   localparam int         PMC_BIT_STOP = 1;
   localparam int         PMC_FLAGS_LSB = 2;
   localparam int         PMC_FLAGS_W = 6;
   localparam logic [5:0] PMC_RESET_FLAGS = 6'h00;

   // ****************************************
   // Types
   // ****************************************
   typedef enum logic [1:0] {PMC_RUN, PMC_IDLE, PMC_STOP} pmc_mode_t;

   // Register-port access from the core
   typedef struct packed {
      logic       wr;
      logic       rd;
      logic [7:0] addr;
      logic [7:0] wdata;
   } pmc_sfr_req_t;

   // Gating outputs toward the rest of the chip
   typedef struct packed {
      logic cpu_clk_en;
      logic periph_clk_en;
      logic irq_en;
   } pmc_gate_t;
endpackage

`default_nettype wire

// *** rtl/pmc_power_mode_ctrl.sv ***
// Design: CPU idle/stop mode controller with general-purpose flags
`timescale 1ns/1ps
`default_nettype none

// Summary of operation
// [RULE_01] Idle bit halts CPU after instruction retires
// [RULE_02] Idle keeps state; peripherals, interrupts clocked
// [RULE_03] Enabled interrupt ends idle, clears idle bit
// [RULE_04] Core resumes after idle-setting instruction
// [RULE_05] Reset during idle gives full reset
// [RULE_06] Firmware follows idle write with multibyte instruction
// [RULE_07] Stop bit halts CPU, timers, interrupts
// [RULE_08] Only reset ends stop mode
// [RULE_09] System clock keeps running in stop
// [RULE_10] Firmware disables analog peripherals before stop
// [RULE_11] Idle and stop bits read as zero
// [RULE_12] Bits 7..2 are plain flags, reset zero
// [RULE_13] Shutdown mode; wake on grounded input
// [RULE_14] Mode write applied at instruction retire
module pmc_power_mode_ctrl (
   input  wire logic                 CLOCK,        // System clock, 100 MHz
   input  wire logic                 RST,          // Synchronous reset, active high
   input  wire pmc_pkg::pmc_sfr_req_t SFR_REQ,     // Register access from core
   output logic [7:0]                SFR_RDATA,    // Read data, registered
   input  wire logic                 INSN_RETIRE,  // Core: current instruction done
   input  wire logic                 IRQ_PENDING,  // Any enabled interrupt asserted
   input  wire logic                 SHUTDOWN_REQ, // Firmware shutdown request
   input  wire logic                 WAKE_PIN,     // Wake input, active low level
   output pmc_pkg::pmc_gate_t        GATE,         // Clock and interrupt enables
   output logic                      PWR_DOWN,     // Power-down request to supply
   output logic [1:0]                MODE          // Current mode code
);
   pmc_pkg::pmc_mode_t mode_r;
   logic [5:0]         flags_r;
   logic               idle_pend_r;
   logic               stop_pend_r;
   logic               pwr_down_r;
   logic               wake_s1_r;
   logic               wake_s2_r;
   logic               pwr_ctl_wr;
   logic               pwr_ctl_rd;

   // ****************************************
   // Register port decode
   // ****************************************
   assign pwr_ctl_wr = SFR_REQ.wr && (SFR_REQ.addr == pmc_pkg::PMC_ADDR_POWER_CONTROL);
   assign pwr_ctl_rd = SFR_REQ.rd && (SFR_REQ.addr == pmc_pkg::PMC_ADDR_POWER_CONTROL);

   // Flags: plain storage, no hardware effect
   always_ff @(posedge CLOCK) begin
      if (RST) begin
         flags_r <= pmc_pkg::PMC_RESET_FLAGS; // RULE_12
      end else if (pwr_ctl_wr) begin
         flags_r <= SFR_REQ.wdata[pmc_pkg::PMC_FLAGS_LSB +: pmc_pkg::PMC_FLAGS_W]; // RULE_12
      end
   end

   // Read data; mode bits never read back as set
   always_ff @(posedge CLOCK) begin
      if (RST) begin
         SFR_RDATA <= pmc_pkg::PMC_RESET_POWER_CONTROL;
      end else if (pwr_ctl_rd) begin
         SFR_RDATA <= {flags_r, 2'h0}; // RULE_11 RULE_12
      end else begin
         SFR_RDATA <= 8'h00;
      end
   end

   // ****************************************
   // Mode entry and exit
   // ****************************************
   // Latch write; applied when the writing instruction retires
   // Mode-bit writes while halted are dropped, so no stale bit re-enters a mode on wake
   always_ff @(posedge CLOCK) begin
      if (RST) begin
         idle_pend_r <= 1'b0;
         stop_pend_r <= 1'b0;
      end else if (pwr_ctl_wr && mode_r == pmc_pkg::PMC_RUN) begin
         idle_pend_r <= SFR_REQ.wdata[pmc_pkg::PMC_BIT_IDLE]; // RULE_14
         stop_pend_r <= SFR_REQ.wdata[pmc_pkg::PMC_BIT_STOP]; // RULE_14
      end else if (INSN_RETIRE) begin
         idle_pend_r <= 1'b0;
         stop_pend_r <= 1'b0;
      end
   end

   // Mode machine; reset ends idle or stop with a full reset
   always_ff @(posedge CLOCK) begin
      if (RST) begin
         mode_r <= pmc_pkg::PMC_RUN; // RULE_05 RULE_08
      end else begin
         unique case (mode_r)
            pmc_pkg::PMC_RUN: begin
               // Stop wins if both bits are written together
               if (stop_pend_r && INSN_RETIRE && !pwr_ctl_wr) begin
                  mode_r <= pmc_pkg::PMC_STOP; // RULE_07
               end else if (idle_pend_r && INSN_RETIRE && !pwr_ctl_wr) begin
                  mode_r <= pmc_pkg::PMC_IDLE; // RULE_01
               end
            end
            pmc_pkg::PMC_IDLE: begin
               // CPU clock simply resumes, so the PC continues past the setter
               if (IRQ_PENDING) begin
                  mode_r <= pmc_pkg::PMC_RUN; // RULE_03 RULE_04
               end
            end
            pmc_pkg::PMC_STOP: begin
               mode_r <= pmc_pkg::PMC_STOP; // RULE_08
            end
            default: begin
               mode_r <= pmc_pkg::PMC_RUN; // Unused code falls back to run
            end
         endcase
      end
   end

   // ****************************************
   // Shutdown and wake
   // ****************************************
   // Wake pin is asynchronous; two flops before use
   always_ff @(posedge CLOCK) begin
      if (RST) begin
         wake_s1_r <= 1'b1;
         wake_s2_r <= 1'b1;
      end else begin
         wake_s1_r <= WAKE_PIN;
         wake_s2_r <= wake_s1_r;
      end
   end

   // Shutdown latch; released by a grounded wake pin
   always_ff @(posedge CLOCK) begin
      if (RST) begin
         pwr_down_r <= 1'b0;
      end else if (!wake_s2_r) begin
         pwr_down_r <= 1'b0; // RULE_13
      end else if (SHUTDOWN_REQ) begin
         pwr_down_r <= 1'b1; // RULE_13
      end
   end

   // ****************************************
   // Outputs
   // ****************************************
   // State is held by gating the CPU clock, never by reset
   always_comb begin
      GATE.cpu_clk_en    = (mode_r == pmc_pkg::PMC_RUN);  // RULE_01 RULE_07
      GATE.periph_clk_en = (mode_r != pmc_pkg::PMC_STOP); // RULE_02 RULE_07
      GATE.irq_en        = (mode_r != pmc_pkg::PMC_STOP); // RULE_02 RULE_07
   end
   // System clock itself is never gated here
   assign PWR_DOWN = pwr_down_r; // RULE_13
   assign MODE     = mode_r;

   // ****************************************
   // Checks
   // ****************************************
   // Entry takes two steps: the write, then the writer's own retire
   sequence s_idle_arm;
      pwr_ctl_wr && SFR_REQ.wdata[0] && !SFR_REQ.wdata[1] && mode_r == pmc_pkg::PMC_RUN;
   endsequence
   sequence s_stop_arm;
      pwr_ctl_wr && SFR_REQ.wdata[1] && mode_r == pmc_pkg::PMC_RUN;
   endsequence
   sequence s_retire;
      !pwr_ctl_wr && INSN_RETIRE;
   endsequence

   // Mode entry and exit
   AST_IDLE_ENTRY: assert property (@(posedge CLOCK) disable iff (RST) // RULE_01
      s_idle_arm ##1 s_retire |=> mode_r == pmc_pkg::PMC_IDLE)
      else $error("idle not entered after retire");
   AST_STOP_ENTRY: assert property (@(posedge CLOCK) disable iff (RST) // RULE_07
      s_stop_arm ##1 s_retire |=> mode_r == pmc_pkg::PMC_STOP)
      else $error("stop not entered after retire");
   AST_NO_EARLY_ENTRY: assert property (@(posedge CLOCK) disable iff (RST) // RULE_14
      s_idle_arm ##1 !INSN_RETIRE |=> mode_r == pmc_pkg::PMC_RUN)
      else $error("mode entered before retire");
   AST_IDLE_WAKE: assert property (@(posedge CLOCK) disable iff (RST) // RULE_03
      mode_r == pmc_pkg::PMC_IDLE && IRQ_PENDING |=> GATE.cpu_clk_en)
      else $error("interrupt did not end idle");
   AST_IDLE_CLR: assert property (@(posedge CLOCK) disable iff (RST) // RULE_03
      mode_r == pmc_pkg::PMC_RUN ##1 mode_r == pmc_pkg::PMC_IDLE |-> !idle_pend_r && !stop_pend_r)
      else $error("mode bit still pending in idle");
   AST_RESUME_RUN: assert property (@(posedge CLOCK) disable iff (RST) // RULE_04
      mode_r == pmc_pkg::PMC_IDLE && IRQ_PENDING |=> mode_r == pmc_pkg::PMC_RUN ##1 mode_r == pmc_pkg::PMC_RUN)
      else $error("core did not resume after wake");

   // Gating and state per mode
   AST_IDLE_PERIPH: assert property (@(posedge CLOCK) disable iff (RST) // RULE_02
      mode_r == pmc_pkg::PMC_IDLE |-> GATE.periph_clk_en && GATE.irq_en && !GATE.cpu_clk_en)
      else $error("idle gating wrong");
   AST_STOP_HOLD: assert property (@(posedge CLOCK) disable iff (RST) // RULE_08
      mode_r == pmc_pkg::PMC_STOP |=> mode_r == pmc_pkg::PMC_STOP)
      else $error("stop left without reset");
   AST_STOP_GATE: assert property (@(posedge CLOCK) disable iff (RST) // RULE_07
      mode_r == pmc_pkg::PMC_STOP |-> !GATE.cpu_clk_en && !GATE.irq_en && !GATE.periph_clk_en)
      else $error("stop gating wrong");
   AST_IDLE_STATE: assert property (@(posedge CLOCK) disable iff (RST) // RULE_02
      mode_r == pmc_pkg::PMC_IDLE && !pwr_ctl_wr |=> $stable(flags_r))
      else $error("flags changed in idle");

   // Register port and reset
   AST_READ_ZERO: assert property (@(posedge CLOCK) disable iff (RST) // RULE_11
      pwr_ctl_rd |=> SFR_RDATA[1:0] == 2'h0 && SFR_RDATA[7:2] == $past(flags_r))
      else $error("power control read wrong");
   AST_FLAGS_WRITE: assert property (@(posedge CLOCK) disable iff (RST) // RULE_12
      pwr_ctl_wr |=> flags_r == $past(SFR_REQ.wdata[7:2]))
      else $error("flags not written");
   AST_RESET_RUN: assert property (@(posedge CLOCK) // RULE_05
      RST |=> mode_r == pmc_pkg::PMC_RUN && flags_r == 6'h00)
      else $error("reset did not restore run");

   // Shutdown and wake
   AST_WAKE: assert property (@(posedge CLOCK) disable iff (RST) // RULE_13
      PWR_DOWN && !WAKE_PIN ##1 !WAKE_PIN |=> ##1 !PWR_DOWN)
      else $error("wake pin ignored");
   AST_SHUT_SET: assert property (@(posedge CLOCK) disable iff (RST) // RULE_13
      SHUTDOWN_REQ && wake_s2_r |=> PWR_DOWN)
      else $error("shutdown request ignored");
endmodule

`default_nettype wire

// *** test/pmc_core_model.sv ***
// Core model: retires instructions while its clock is enabled
`timescale 1ns/1ps
`default_nettype none
module pmc_core_model (
   input  wire logic CLOCK,  // System clock
   input  wire logic RST,    // Sync reset
   input  wire logic cpu_en, // CPU clock enable
   input  wire logic slow,   // Retire every fourth cycle
   output logic      retire  // Instruction done pulse
);
   logic [1:0] cnt_r;
   // Retires on every enabled cycle, or, when slow is set, on every fourth cycle of a free-running count if enabled then
   always @(negedge CLOCK) begin
      cnt_r <= RST ? 2'h0 : cnt_r + 2'h1;
      retire <= !RST && cpu_en && (!slow || cnt_r == 2'h3);
   end
endmodule
`default_nettype wire

// *** test/pmc_power_mode_ctrl_tb.sv ***
// Testbench: register, idle, stop and shutdown checks
`timescale 1ns/1ps
`default_nettype none
module pmc_power_mode_ctrl_tb;
   logic                  clk, rst, retire, irq, shut, wake, slow, pwr;
   pmc_pkg::pmc_sfr_req_t req;
   pmc_pkg::pmc_gate_t    gate;
   logic [7:0]            rdata;
   logic [1:0]            mode;
   int                    fail_count, compares;
   pmc_power_mode_ctrl pmc_power_mode_ctrl_i (.CLOCK(clk), .RST(rst), .SFR_REQ(req), .SFR_RDATA(rdata),
      .INSN_RETIRE(retire), .IRQ_PENDING(irq), .SHUTDOWN_REQ(shut), .WAKE_PIN(wake), .GATE(gate),
      .PWR_DOWN(pwr), .MODE(mode));
   pmc_core_model pmc_core_model_i (.CLOCK(clk), .RST(rst), .cpu_en(gate.cpu_clk_en), .slow(slow), .retire(retire));
   // Verdict
   task automatic complete_run();
      $display("fail_count=%0d compares=%0d", fail_count, compares);
      if (fail_count == 0 && compares > 0) begin
         $display("verification passed");
      end else begin
         $display("verification failed");
      end
      $finish;
   endtask
   task automatic chk(input logic [7:0] got, input logic [7:0] exp);
      compares++;
      if (got !== exp) begin
         fail_count++;
         $display("ERROR t=%0t got=%h exp=%h", $time, got, exp);
      end
   endtask
   // Bus cycles, one cycle strobes
   task automatic wr(input logic [7:0] a, input logic [7:0] d);
      @(negedge clk);
      req <= '{1'b1, 1'b0, a, d};
      @(negedge clk);
      req <= '0;
   endtask
   task automatic rd(input logic [7:0] a, input logic [7:0] exp);
      @(negedge clk);
      req <= '{1'b0, 1'b1, a, 8'h00};
      @(negedge clk);
      req <= '0;
      chk(rdata, exp);
   endtask
   // Bounded wait; a hang ends the run
   task automatic wait_mode(input logic [1:0] m);
      int n;
      n = 0;
      while (mode !== m && n < 20) begin
         @(negedge clk);
         n++;
      end
      chk({6'h00, mode}, {6'h00, m});
      if (mode !== m) complete_run(); // Timed out; mismatch already counted
   endtask
   task automatic reset_exit();
      rst <= 1'b1;
      @(negedge clk);
      rst <= 1'b0;
      chk({6'h00, mode}, 8'h00);
      rd(8'h87, 8'h00);
   endtask
   task automatic t_reg();
      rd(8'h87, 8'h00);
      chk({5'h00, gate}, 8'h07);
      wr(8'h87, 8'hA8);
      wr(8'h86, 8'hFC);
      rd(8'h87, 8'hA8);
      rd(8'h86, 8'h00);
   endtask
   // Write retiring in the same cycle must not count
   task automatic t_idle(input logic s);
      slow <= s;
      wr(8'h87, 8'hFD);
      chk({6'h00, mode}, 8'h00);
      wait_mode(2'h1);
      chk({5'h00, gate}, 8'h03);
      rd(8'h87, 8'hFC);
      irq <= 1'b1;
      @(negedge clk);
      irq <= 1'b0;
      chk({5'h00, gate}, 8'h07);
      rd(8'h87, 8'hFC);
      chk({6'h00, mode}, 8'h00);
   endtask
   // Both bits set: stop wins; interrupts ignored
   task automatic t_stop();
      wr(8'h87, 8'h07);
      wait_mode(2'h2);
      chk({5'h00, gate}, 8'h00);
      rd(8'h87, 8'h04);
      irq <= 1'b1;
      repeat (5) @(negedge clk);
      irq <= 1'b0;
      chk({6'h00, mode}, 8'h02);
   endtask
   task automatic t_shut();
      shut <= 1'b1;
      @(negedge clk);
      shut <= 1'b0;
      wake <= 1'b0;
      chk({7'h00, pwr}, 8'h01);
      repeat (2) @(negedge clk);
      chk({7'h00, pwr}, 8'h01);
      @(negedge clk);
      chk({7'h00, pwr}, 8'h00);
      wake <= 1'b1;
   endtask
   initial begin
      clk = 1'b1;
      forever #5 clk = ~clk;
   end
   // Main sequence
   initial begin
      fail_count = 0;
      compares = 0;
      {rst, req, irq, shut, wake, slow} = {1'b1, 18'h0, 4'h2};
      repeat (6) @(negedge clk);
      rst <= 1'b0;
      t_reg();
      t_idle(1'b0);
      t_idle(1'b1);
      wr(8'h87, 8'h01);
      wait_mode(2'h1);
      reset_exit();
      t_stop();
      reset_exit();
      t_shut();
      complete_run();
   end
endmodule
`default_nettype wire
